// ==== design/ccps_pkg.sv ====
// Constants for the charge cycle and power selector control block.
// Assumes a 200 MHz core clock and comparator-level inputs.
package ccps_pkg;

    localparam int CLK_MHZ = 200;

    localparam int PWRUP_DELAY_MS   = 30;
    localparam int SEL_WAKE_MS      = 30;
    localparam int DEAD_TIME_NS     = 10000;
    localparam int RAMP_STEP_US     = 1600;
    localparam int TIMER_TICK_US    = 6000000;
    localparam int PRE_TIMEOUT_MIN  = 30;

    // Cycle counts; long times are exact products, dead time rounds up
    localparam logic [31:0] PWRUP_CYCLES     = 32'(CLK_MHZ * 1000 * PWRUP_DELAY_MS);
    localparam logic [31:0] SEL_WAKE_CYCLES  = 32'(CLK_MHZ * 1000 * SEL_WAKE_MS);
    localparam logic [31:0] DEAD_CYCLES      = 32'((DEAD_TIME_NS * CLK_MHZ + 999) / 1000);
    localparam logic [31:0] RAMP_STEP_CYCLES = 32'(CLK_MHZ * RAMP_STEP_US);
    localparam logic [31:0] TICK_CYCLES      = 32'(CLK_MHZ * TIMER_TICK_US);

    // One timer tick is a tenth of a minute
    localparam logic [8:0]  PRE_TIMEOUT_TICKS = 9'(PRE_TIMEOUT_MIN * 10);
    localparam logic [13:0] KTTC_TICKS_PER_NF = 14'h038;
    localparam logic [3:0]  RAMP_STEPS        = 4'h8;

    // Realised by the two die comparators
    localparam int DIE_HOT_C  = 145;
    localparam int DIE_HYST_C = 15;

    localparam int IX_SUPPLY_ABOVE = 0;
    localparam int IX_SUPPLY_NEAR  = 1;
    localparam int IX_UVLO         = 2;
    localparam int IX_LOW_SUPPLY   = 3;
    localparam int IX_OVERVOLT     = 4;
    localparam int IX_REG_GOOD     = 5;
    localparam int IX_DIE_HOT      = 6;
    localparam int IX_DIE_COOL     = 7;
    localparam int IX_TEMP_FAULT   = 8;
    localparam int IX_CE           = 9;
    localparam int IX_ABOVE_EXIT   = 10;
    localparam int IX_FB_ABOVE     = 11;
    localparam int IX_CUR_BELOW    = 12;
    localparam int IX_CV_MODE      = 13;
    localparam int IX_INPUT_OVER   = 14;
    localparam int IX_TTC_LOW      = 15;
    localparam int IX_TTC_REF      = 16;
    localparam int IX_NF_LSB       = 17;
    localparam int NF_WIDTH        = 8;
    localparam int SYNC_WIDTH      = 25;

    typedef enum logic [5:0] {
        CHG_IDLE  = 6'h01,
        CHG_PRE   = 6'h02,
        CHG_FAST  = 6'h04,
        CHG_VREG  = 6'h08,
        CHG_DONE  = 6'h10,
        CHG_FAULT = 6'h20
    } ccps_chg_t;

    typedef enum logic [4:0] {
        SEL_BATT     = 5'h01,
        SEL_WAKE     = 5'h02,
        SEL_DEAD_AD  = 5'h04,
        SEL_ADAPTER  = 5'h08,
        SEL_DEAD_BAT = 5'h10
    } ccps_sel_t;

endpackage

// ==== design/ccps_sync.sv ====
// Two-stage synchroniser bank for the comparator and pin levels.
// Assumes each bit is a level from outside the core clock domain.
`timescale 1ns/100ps
module ccps_sync #(
    parameter int WIDTH = 25
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } ccps_sync_state_t;

    ccps_sync_state_t st;
    ccps_sync_state_t next_st;

    always_comb begin
        next_st.stage1 = async_in;
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.stage2;
endmodule

// ==== design/ccps_top.sv ====
// Charge cycle sequencer and system power selector of a stand-alone charger.
// Assumes analog comparator levels and a power-on reset on rst_n.
`timescale 1ns/100ps
module ccps_top
    import ccps_pkg::*;
#(
    parameter logic [31:0] PWRUP_CYC = PWRUP_CYCLES,
    parameter logic [31:0] WAKE_CYC  = SEL_WAKE_CYCLES,
    parameter logic [31:0] RAMP_CYC  = RAMP_STEP_CYCLES,
    parameter logic [31:0] TICK_CYC  = TICK_CYCLES
) (
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    input  wire logic                supply_above_battery,
    input  wire logic                supply_near_battery,
    input  wire logic                undervoltage_lockout,
    input  wire logic                low_supply_state,
    input  wire logic                input_overvoltage,
    input  wire logic                gate_supply_regulator_good,
    input  wire logic                die_temp_hot,
    input  wire logic                die_temp_cool,
    input  wire logic                battery_temp_sense_fault,
    input  wire logic                charge_enable_pin,
    input  wire logic                battery_above_precharge_exit,
    input  wire logic                voltage_feedback_above_recharge,
    input  wire logic                charge_current_below_term,
    input  wire logic                voltage_regulation_mode,
    input  wire logic                input_current_over_limit,
    input  wire logic                timer_capacitor_pin_low,
    input  wire logic                timer_capacitor_pin_at_ref,
    input  wire logic [NF_WIDTH-1:0] timer_capacitor_nf,
    output logic                     adapter_switch_drive,
    output logic                     battery_switch_drive,
    output logic                     charge_enable,
    output logic                     precharge_current_select,
    output logic [3:0]               charge_current_step,
    output logic                     input_power_management_active,
    output logic                     charge_fault,
    output logic                     charge_done,
    output logic                     sleep_mode,
    output logic                     die_overtemperature
);
    typedef struct packed {
        ccps_chg_t   chg;
        ccps_sel_t   sel;
        logic [31:0] pwrup_cnt;
        logic        pwrup_done;
        logic [31:0] sel_cnt;
        logic [31:0] tick_cnt;
        logic [8:0]  pre_ticks;
        logic [13:0] safety_ticks;
        logic [3:0]  ramp_step;
        logic [31:0] ramp_cnt;
        logic        die_hot;
        logic        ce_d;
        logic        ovp_d;
        logic        low_d;
        logic        sleep_d;
        logic        ad_drv;
        logic        bat_drv;
        logic        chg_en;
        logic        pre_sel;
        logic        input_power_management;
        logic        fault;
        logic        done;
    } ccps_state_t;

    localparam ccps_state_t ST_RESET = '{chg: CHG_IDLE, sel: SEL_BATT, bat_drv: 1'b1, default: '0};

    ccps_state_t           st;
    ccps_state_t           next_st;
    logic [SYNC_WIDTH-1:0] raw_in;
    logic [SYNC_WIDTH-1:0] s;

    function automatic logic [13:0] safety_limit(input logic [NF_WIDTH-1:0] nf);
        return 14'(nf) * KTTC_TICKS_PER_NF;
    endfunction

    // A zero limit counts as one
    function automatic logic reached(input logic [31:0] cnt, input logic [31:0] lim);
        return (cnt + 32'h1 >= lim);
    endfunction

    assign raw_in = {timer_capacitor_nf, timer_capacitor_pin_at_ref, timer_capacitor_pin_low,
                     input_current_over_limit, voltage_regulation_mode,
                     charge_current_below_term, voltage_feedback_above_recharge,
                     battery_above_precharge_exit, charge_enable_pin,
                     battery_temp_sense_fault, die_temp_cool, die_temp_hot,
                     gate_supply_regulator_good, input_overvoltage, low_supply_state,
                     undervoltage_lockout, supply_near_battery, supply_above_battery};

    ccps_sync #(
        .WIDTH(SYNC_WIDTH)
    ) u_sync (
        .core_clk(core_clk),
        .rst_n   (rst_n),
        .async_in(raw_in),
        .sync_out(s)
    );

    logic        sleep_now;
    logic        charge_ok;
    logic        new_cycle;
    logic        timer_reset;
    logic        timer_run;
    logic        timer_expired;
    logic        term_enable;
    logic        tick;
    logic [13:0] limit;

    always_comb begin
        next_st = st;

        sleep_now = !s[IX_SUPPLY_ABOVE];
        tick      = reached(st.tick_cnt, TICK_CYC);
        limit     = safety_limit(s[IX_NF_LSB +: NF_WIDTH]);

        // One free-running prescaler serves both long timers
        next_st.tick_cnt = tick ? 32'h0 : st.tick_cnt + 32'h1;

        if (!st.pwrup_done) begin
            next_st.pwrup_cnt  = st.pwrup_cnt + 32'h1;
            next_st.pwrup_done = reached(st.pwrup_cnt, PWRUP_CYC);
        end

        // Hot sets, cool clears; hot wins
        if (s[IX_DIE_HOT]) begin
            next_st.die_hot = 1'b1;
        end else if (s[IX_DIE_COOL]) begin
            next_st.die_hot = 1'b0;
        end

        next_st.ce_d    = s[IX_CE];
        next_st.ovp_d   = s[IX_OVERVOLT];
        next_st.low_d   = s[IX_LOW_SUPPLY];
        next_st.sleep_d = sleep_now;

        charge_ok = s[IX_CE] && !s[IX_UVLO] && !s[IX_LOW_SUPPLY] && !sleep_now
                    && !s[IX_OVERVOLT] && st.pwrup_done && s[IX_REG_GOOD]
                    && !st.die_hot && !s[IX_TEMP_FAULT];

        new_cycle = (s[IX_CE] != st.ce_d)
                    || (st.chg == CHG_DONE && !s[IX_FB_ABOVE]);

        term_enable = !s[IX_TTC_LOW];
        timer_reset = new_cycle || s[IX_TTC_LOW]
                      || (st.ovp_d && !s[IX_OVERVOLT])
                      || (st.low_d && !s[IX_LOW_SUPPLY])
                      || (st.sleep_d && !sleep_now);
        timer_run   = !s[IX_TTC_LOW] && !s[IX_TTC_REF]
                      && (st.chg == CHG_PRE || st.chg == CHG_FAST || st.chg == CHG_VREG);
        timer_expired = timer_run && (limit != 14'h0) && (st.safety_ticks >= limit);

        if (timer_reset) begin
            next_st.safety_ticks = 14'h0;
        end else if (timer_run && tick && !timer_expired) begin
            next_st.safety_ticks = st.safety_ticks + 14'h1;
        end

        unique case (st.chg)
            CHG_IDLE: begin
                if (charge_ok) begin
                    if (s[IX_ABOVE_EXIT]) begin
                        next_st.chg       = CHG_FAST;
                        next_st.ramp_step = 4'h1;
                        next_st.ramp_cnt  = 32'h0;
                    end else begin
                        next_st.chg       = CHG_PRE;
                        next_st.pre_ticks = 9'h0;
                    end
                end
            end
            CHG_PRE: begin
                if (!charge_ok) begin
                    next_st.chg = CHG_IDLE;
                end else if (timer_expired
                             || st.pre_ticks >= PRE_TIMEOUT_TICKS) begin
                    next_st.chg = CHG_FAULT;
                end else if (s[IX_ABOVE_EXIT]) begin
                    next_st.chg       = CHG_FAST;
                    next_st.ramp_step = 4'h1;
                    next_st.ramp_cnt  = 32'h0;
                end else if (tick) begin
                    next_st.pre_ticks = st.pre_ticks + 9'h1;
                end
            end
            CHG_FAST, CHG_VREG: begin
                if (!charge_ok) begin
                    next_st.chg = CHG_IDLE;
                end else if (timer_expired) begin
                    next_st.chg = CHG_FAULT;
                end else if (st.chg == CHG_VREG && term_enable && s[IX_FB_ABOVE]
                             && s[IX_CUR_BELOW]) begin
                    next_st.chg = CHG_DONE;
                end else if (st.chg == CHG_FAST && s[IX_CV_MODE]) begin
                    next_st.chg = CHG_VREG;
                end
                // Ramp keeps stepping in regulation so the target never sticks low
                if (st.ramp_step < RAMP_STEPS) begin
                    if (reached(st.ramp_cnt, RAMP_CYC)) begin
                        next_st.ramp_cnt  = 32'h0;
                        next_st.ramp_step = st.ramp_step + 4'h1;
                    end else begin
                        next_st.ramp_cnt = st.ramp_cnt + 32'h1;
                    end
                end
            end
            CHG_DONE: begin
                if (new_cycle) begin
                    next_st.chg = CHG_IDLE;
                end
            end
            CHG_FAULT: begin
                if (new_cycle) begin
                    next_st.chg = CHG_IDLE;
                end
            end
            default: begin
                next_st.chg = CHG_IDLE;
            end
        endcase

        if (next_st.chg != CHG_FAST && next_st.chg != CHG_VREG) begin
            next_st.ramp_step = 4'h0;
        end

        // Lockout overrides every selector state at once
        unique case (st.sel)
            SEL_BATT: begin
                if (!s[IX_UVLO] && !sleep_now && !s[IX_OVERVOLT]) begin
                    next_st.sel     = SEL_WAKE;
                    next_st.sel_cnt = 32'h0;
                end
            end
            SEL_WAKE: begin
                if (s[IX_UVLO] || sleep_now || s[IX_OVERVOLT]) begin
                    next_st.sel = SEL_BATT;
                end else if (reached(st.sel_cnt, WAKE_CYC)) begin
                    next_st.sel     = SEL_DEAD_AD;
                    next_st.sel_cnt = 32'h0;
                end else begin
                    next_st.sel_cnt = st.sel_cnt + 32'h1;
                end
            end
            SEL_DEAD_AD: begin
                if (s[IX_UVLO]) begin
                    next_st.sel = SEL_BATT;
                end else if (reached(st.sel_cnt, DEAD_CYCLES)) begin
                    next_st.sel = SEL_ADAPTER;
                end else begin
                    next_st.sel_cnt = st.sel_cnt + 32'h1;
                end
            end
            SEL_ADAPTER: begin
                if (s[IX_UVLO]) begin
                    next_st.sel = SEL_BATT;
                end else if (s[IX_SUPPLY_NEAR] || sleep_now || s[IX_OVERVOLT]) begin
                    next_st.sel     = SEL_DEAD_BAT;
                    next_st.sel_cnt = 32'h0;
                end
            end
            SEL_DEAD_BAT: begin
                if (s[IX_UVLO] || reached(st.sel_cnt, DEAD_CYCLES)) begin
                    next_st.sel = SEL_BATT;
                end else begin
                    next_st.sel_cnt = st.sel_cnt + 32'h1;
                end
            end
            default: begin
                next_st.sel = SEL_BATT;
            end
        endcase

        // Outputs register the next state so drives never glitch
        next_st.ad_drv  = (next_st.sel == SEL_ADAPTER);
        next_st.bat_drv = (next_st.sel == SEL_BATT || next_st.sel == SEL_WAKE);
        next_st.chg_en  = (next_st.chg == CHG_PRE || next_st.chg == CHG_FAST
                           || next_st.chg == CHG_VREG);
        next_st.pre_sel = (next_st.chg == CHG_PRE);
        next_st.input_power_management     = next_st.chg_en && s[IX_INPUT_OVER];
        next_st.fault   = (next_st.chg == CHG_FAULT);
        next_st.done    = (next_st.chg == CHG_DONE);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign adapter_switch_drive          = st.ad_drv;
    assign battery_switch_drive          = st.bat_drv;
    assign charge_enable                 = st.chg_en;
    assign precharge_current_select      = st.pre_sel;
    assign charge_current_step           = st.ramp_step;
    assign input_power_management_active = st.input_power_management;
    assign charge_fault                  = st.fault;
    assign charge_done                   = st.done;
    assign sleep_mode                    = st.sleep_d;
    assign die_overtemperature           = st.die_hot;
endmodule

// ==== dv/ccps_power_model.sv ====
// Behavioural adapter, battery pack and system switch network.
// Assumes ccps_top drive levels; comparators move at the falling edge.
`timescale 1ns/100ps
module ccps_power_model #(
    parameter int DECAY = 5
) (
    input  wire logic core_clk,
    input  wire logic adapter_plugged,
    input  wire logic adapter_switch_drive,
    input  wire logic battery_switch_drive,
    output logic      supply_above_battery,
    output logic      supply_near_battery
);
    int decay = 0;

    initial begin
        supply_above_battery = 1'b0;
        supply_near_battery  = 1'b0;
    end

    // Supply reaches the near level before the battery takes over
    always @(negedge core_clk) begin
        if (adapter_plugged) begin
            decay                <= 0;
            supply_above_battery <= 1'b1;
            supply_near_battery  <= 1'b0;
        end else begin
            decay               <= (decay < DECAY) ? decay + 1 : decay;
            supply_near_battery <= (decay >= DECAY);
            if (battery_switch_drive && !adapter_switch_drive) begin
                supply_above_battery <= 1'b0;
            end
        end
    end
endmodule

// ==== dv/ccps_top_props.sv ====
// Concurrent checks on the ccps_top ports.
// Assumes a bind into ccps_top; sees its ports only.
`timescale 1ns/100ps
module ccps_top_props
    import ccps_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       supply_above_battery,
    input wire logic       undervoltage_lockout,
    input wire logic       die_temp_hot,
    input wire logic       charge_enable_pin,
    input wire logic       adapter_switch_drive,
    input wire logic       battery_switch_drive,
    input wire logic       charge_enable,
    input wire logic       precharge_current_select,
    input wire logic [3:0] charge_current_step,
    input wire logic       input_power_management_active,
    input wire logic       charge_fault,
    input wire logic       charge_done,
    input wire logic       sleep_mode,
    input wire logic       die_overtemperature
);
    localparam int DEAD_MAX = 2001;
    logic [3:0]  age;
    logic [15:0] off_cnt;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // Saturating counters: a wrap would fake a short dead time
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            age     <= 4'h0;
            off_cnt <= 16'h0000;
        end else begin
            age     <= (age == 4'hf) ? age : age + 4'h1;
            off_cnt <= (adapter_switch_drive | battery_switch_drive) ? 16'h0000 :
                       (off_cnt == 16'hffff) ? off_cnt : off_cnt + 16'h0001;
        end
    end

    sequence s_lockout;
        undervoltage_lockout [*5];
    endsequence
    sequence s_hot;
        die_temp_hot [*5];
    endsequence

    chk_no_overlap: assert property (!(adapter_switch_drive && battery_switch_drive))
        else $error("switches overlap");
    chk_adapter_dead: assert property ($rose(adapter_switch_drive) |->
        off_cnt >= DEAD_CYCLES && off_cnt <= DEAD_MAX)
        else $error("short dead time");
    chk_dead_bound: assert property (off_cnt <= DEAD_MAX)
        else $error("long dead time");
    chk_lockout_batt: assert property (s_lockout |->
        battery_switch_drive && !adapter_switch_drive)
        else $error("lockout not on battery");
    chk_sleep_track: assert property (age >= 4'h5 |->
        sleep_mode == !$past(supply_above_battery, 3))
        else $error("sleep flag wrong");
    chk_sleep_stop: assert property (sleep_mode |-> !charge_enable && !adapter_switch_drive)
        else $error("active in sleep");
    chk_ce_low_stop: assert property (!charge_enable_pin [*5] |-> !charge_enable)
        else $error("charge with enable low");
    chk_pre_select: assert property (precharge_current_select |-> charge_enable && !charge_done)
        else $error("stray precharge select");
    chk_step_bound: assert property ((charge_enable || charge_current_step == 4'h0)
        && charge_current_step <= 4'h8)
        else $error("step out of range");
    chk_ramp_inc: assert property ($changed(charge_current_step) && charge_current_step != 4'h0
        |-> charge_current_step == $past(charge_current_step) + 4'h1)
        else $error("step skipped");
    chk_fault_idle: assert property (charge_fault |-> !charge_enable && !charge_done)
        else $error("fault while charging");
    chk_dpm_gate: assert property (input_power_management_active |->
        charge_enable || $past(charge_enable))
        else $error("stray input limit");
    chk_hot_latch: assert property (s_hot |-> die_overtemperature)
        else $error("hot not flagged");
    chk_hot_stop: assert property (die_overtemperature [*2] |-> !charge_enable)
        else $error("charge while hot");
endmodule

bind ccps_top ccps_top_props i_props (
    .core_clk, .rst_n, .supply_above_battery, .undervoltage_lockout, .die_temp_hot,
    .charge_enable_pin, .adapter_switch_drive, .battery_switch_drive, .charge_enable,
    .precharge_current_select, .charge_current_step, .input_power_management_active,
    .charge_fault, .charge_done, .sleep_mode, .die_overtemperature
);

// ==== dv/ccps_top_tb.sv ====
// Self-checking bench for ccps_top.
// Assumes short timing parameters; the dead time keeps full length.
`timescale 1ns/100ps
module ccps_top_tb;
    import ccps_pkg::*;
    logic       core_clk, rst_n, adapter_plugged, undervoltage_lockout, low_supply_state;
    logic       input_overvoltage, gate_supply_regulator_good, die_temp_hot, die_temp_cool;
    logic       battery_temp_sense_fault, charge_enable_pin, battery_above_precharge_exit;
    logic       voltage_feedback_above_recharge, charge_current_below_term;
    logic       voltage_regulation_mode, input_current_over_limit, timer_capacitor_pin_low;
    logic       timer_capacitor_pin_at_ref, supply_above_battery, supply_near_battery;
    logic       adapter_switch_drive, battery_switch_drive, charge_enable, charge_fault;
    logic       precharge_current_select, input_power_management_active, charge_done;
    logic       sleep_mode, die_overtemperature;
    logic [7:0] timer_capacitor_nf;
    logic [3:0] charge_current_step;
    logic [8:0] obs;
    int         err_total, total_checks, waited, k;
    string      names[10] = '{"adapter", "battery", "charge_en", "pre_sel", "fault", "done",
                              "sleep", "die_hot", "dpm", "step"};

    assign obs = {input_power_management_active, die_overtemperature, sleep_mode, charge_done,
                  charge_fault, precharge_current_select, charge_enable, battery_switch_drive,
                  adapter_switch_drive};

    ccps_top #(.PWRUP_CYC(32'h32), .WAKE_CYC(32'h3c), .RAMP_CYC(32'ha), .TICK_CYC(32'h4)) i_dut (
        .core_clk, .rst_n, .supply_above_battery, .supply_near_battery, .undervoltage_lockout,
        .low_supply_state, .input_overvoltage, .gate_supply_regulator_good, .die_temp_hot,
        .die_temp_cool, .battery_temp_sense_fault, .charge_enable_pin,
        .battery_above_precharge_exit, .voltage_feedback_above_recharge,
        .charge_current_below_term, .voltage_regulation_mode, .input_current_over_limit,
        .timer_capacitor_pin_low, .timer_capacitor_pin_at_ref, .timer_capacitor_nf,
        .adapter_switch_drive, .battery_switch_drive, .charge_enable, .precharge_current_select,
        .charge_current_step, .input_power_management_active, .charge_fault, .charge_done,
        .sleep_mode, .die_overtemperature
    );

    ccps_power_model i_power (
        .core_clk, .adapter_plugged, .adapter_switch_drive, .battery_switch_drive,
        .supply_above_battery, .supply_near_battery
    );

    function automatic logic [3:0] probe(input int s);
        probe = (s == 9) ? charge_current_step : {3'h0, obs[s]};
    endfunction

    task automatic chk(input int s, input logic [3:0] exp);
        logic [3:0] got;
        got = probe(s);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %0h seen %0h", names[s], exp, got);
        end
    endtask

    // Bounded poll; waited feeds delay checks
    task automatic wait_val(input int s, input logic [3:0] exp, input int lim);
        waited = 0;
        while (probe(s) !== exp && waited < lim) begin
            @(negedge core_clk);
            waited++;
        end
        chk(s, exp);
    endtask

    task automatic in_range(input int lo, input int hi);
        total_checks++;
        if (waited < lo || waited > hi) begin
            err_total++;
            $display("[FAIL] delay expected %0d..%0d seen %0d", lo, hi, waited);
        end
    endtask

    task automatic run(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic toggle_ce();
        charge_enable_pin = 1'b0;
        run(6);
        charge_enable_pin = 1'b1;
    endtask

    task automatic set_stop(input int s, input logic v);
        case (s)
            0: gate_supply_regulator_good = !v;
            1: battery_temp_sense_fault = v;
            2: input_overvoltage = v;
            3: low_supply_state = v;
            default: charge_enable_pin = !v;
        endcase
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        $display("[FAIL] watchdog expected finish seen timeout");
        summarize();
    end

    initial begin
        {rst_n, undervoltage_lockout, low_supply_state, input_overvoltage, die_temp_hot} = '0;
        {battery_temp_sense_fault, battery_above_precharge_exit, charge_current_below_term} = '0;
        {voltage_feedback_above_recharge, voltage_regulation_mode, input_current_over_limit} = '0;
        {timer_capacitor_pin_low, timer_capacitor_pin_at_ref, timer_capacitor_nf} = '0;
        {adapter_plugged, gate_supply_regulator_good, die_temp_cool, charge_enable_pin} = 4'hf;
        err_total = 0;
        total_checks = 0;
        run(8);
        chk(1, 4'h1);
        chk(0, 4'h0);
        chk(2, 4'h0);
        rst_n = 1'b1;
        wait_val(3, 4'h1, 100);
        in_range(48, 60);
        chk(2, 4'h1);
        wait_val(4, 4'h1, 1400);
        in_range(1180, 1220);
        chk(2, 4'h0);
        wait_val(0, 4'h1, 1000);
        chk(1, 4'h0);
        $display("test precharge done");
        battery_above_precharge_exit = 1'b1;
        toggle_ce();
        wait_val(4, 4'h0, 14);
        wait_val(9, 4'h1, 10);
        for (k = 2; k <= 8; k++) begin
            wait_val(9, 4'(k), 14);
            in_range(9, 11);
        end
        run(30);
        chk(9, 4'h8);
        input_current_over_limit = 1'b1;
        wait_val(8, 4'h1, 5);
        input_current_over_limit = 1'b0;
        wait_val(8, 4'h0, 5);
        $display("test ramp done");
        voltage_regulation_mode = 1'b1;
        charge_current_below_term = 1'b1;
        timer_capacitor_pin_low = 1'b1;
        voltage_feedback_above_recharge = 1'b1;
        run(20);
        chk(2, 4'h1);
        chk(5, 4'h0);
        timer_capacitor_pin_low = 1'b0;
        timer_capacitor_pin_at_ref = 1'b1;
        wait_val(5, 4'h1, 8);
        chk(2, 4'h0);
        voltage_feedback_above_recharge = 1'b0;
        wait_val(2, 4'h1, 12);
        $display("test termination done");
        timer_capacitor_nf = 8'h01;
        toggle_ce();
        run(400);
        chk(4, 4'h0);
        timer_capacitor_pin_at_ref = 1'b0;
        toggle_ce();
        wait_val(4, 4'h1, 300);
        in_range(220, 240);
        chk(2, 4'h0);
        timer_capacitor_nf = 8'h00;
        toggle_ce();
        wait_val(2, 4'h1, 15);
        $display("test timer done");
        for (k = 0; k < 5; k++) begin
            set_stop(k, 1'b1);
            wait_val(2, 4'h0, 8);
            set_stop(k, 1'b0);
            wait_val(2, 4'h1, 20);
        end
        {die_temp_hot, die_temp_cool} = 2'h2;
        wait_val(7, 4'h1, 6);
        wait_val(2, 4'h0, 2);
        die_temp_hot = 1'b0;
        run(10);
        chk(7, 4'h1);
        die_temp_cool = 1'b1;
        wait_val(7, 4'h0, 6);
        wait_val(2, 4'h1, 20);
        $display("test gating done");
        wait_val(0, 4'h1, 4200);
        adapter_plugged = 1'b0;
        wait_val(0, 4'h0, 20);
        chk(1, 4'h0);
        wait_val(1, 4'h1, 2100);
        in_range(1990, 2005);
        wait_val(6, 4'h1, 10);
        chk(2, 4'h0);
        run(100);
        chk(0, 4'h0);
        chk(1, 4'h1);
        adapter_plugged = 1'b1;
        wait_val(0, 4'h1, 2200);
        in_range(2050, 2080);
        undervoltage_lockout = 1'b1;
        wait_val(1, 4'h1, 6);
        chk(0, 4'h0);
        $display("test selector done");
        summarize();
    end
endmodule
